// ### triac_firing_params.svh
// Constants for the phase-angle triac firing controller
// Summary of operation
// RULE1 - The setpoint is quantised into five working levels, level one least power, level five most.
// RULE2 - A level indicator output always shows the currently selected working level.
// RULE3 - A higher setpoint gives a higher working level and a lower setpoint a lower one.
// RULE4 - The drive-active lamp stays steadily on while gate pulses are being issued correctly.
// RULE5 - With the setpoint at off the block is in standby and issues no gate pulses.
// RULE6 - When zero-crossing edges stop, firing halts and the drive-active lamp blinks.
// RULE7 - When zero-crossing edges return, normal control resumes on its own.
// RULE8 - Operation starts right after reset with no start command.
// RULE9 - On 50 Hz mains the delays are 8.5, 7.0, 5.5, 4.0 and 2.5 ms for levels one to five.
// RULE10 - On 60 Hz mains the delays are 7.0, 6.0, 5.0, 3.5 and 2.0 ms for levels one to five.
// RULE11 - The zero-cross input toggles at every mains zero crossing and each edge times the delay.
// RULE12 - Each gate pulse is 1 ms wide and starts once the selected delay has passed.
// RULE13 - The delay moves gradually toward its target, reaching full level in about 4 s.
// RULE14 - Mains frequency is judged from the interval between zero-crossing edges.
// RULE15 - Zero-cross loss is declared after a timeout well beyond a half period.
`ifndef TRIAC_FIRING_PARAMS_SVH
`define TRIAC_FIRING_PARAMS_SVH
`define CLK_HZ 10000000
`define US_TO_CYC(us) ((us) * (`CLK_HZ / 1000000))
// Delays in microseconds
`define DLY50_L1_US 8500
`define DLY50_L2_US 7000
`define DLY50_L3_US 5500
`define DLY50_L4_US 4000
`define DLY50_L5_US 2500
`define DLY60_L1_US 7000
`define DLY60_L2_US 6000
`define DLY60_L3_US 5000
`define DLY60_L4_US 3500
`define DLY60_L5_US 2000
`define GATE_PULSE_US 1000
// Half period above this is 50 Hz (between 8.33 and 10 ms)
`define FREQ_SPLIT_US 9170
`define ZC_TIMEOUT_US 30000
`define RAMP_TIME_US 4000000
`define BLINK_HALF_US 250000
`define TIMER_W 24
`endif

// ### triac_firing_pkg.sv
// Types for the phase-angle triac firing controller
package triac_firing_pkg;
   typedef enum logic [1:0] {
      ST_STANDBY = 2'b00,
      ST_DELAY = 2'b01,
      ST_PULSE = 2'b11,
      ST_WAIT = 2'b10
   } fire_state_e;
   typedef struct packed {
      logic run_lamp;
      logic [4:0] level_leds;
   } indicator_s;
endpackage

// ### phase_angle_triac_firing.sv
// Phase-angle triac firing controller top level
`timescale 1ns/1ps
`include "triac_firing_params.svh"
module phase_angle_triac_firing
   import triac_firing_pkg::*;
#(
   parameter int SETPOINT_W = 8,
   parameter int ZC_TIMEOUT_CYC = `US_TO_CYC(`ZC_TIMEOUT_US),
   parameter int RAMP_TIME_CYC = `US_TO_CYC(`RAMP_TIME_US),
   parameter int BLINK_HALF_CYC = `US_TO_CYC(`BLINK_HALF_US)
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Mains and setpoint
   input wire logic mains_zero_cross_input,
   input wire logic [SETPOINT_W-1:0] power_setpoint_knob,
   // Power stage
   output logic triac_gate,
   // Indicators
   output indicator_s indicators,
   output logic [2:0] working_level,
   output logic mains_60hz,
   output logic zc_lost
);
   localparam int TW = `TIMER_W;
   localparam int STEPS = 5 * 6;
   // Ramp moves one 0.1 ms step per tick; about 60 steps across the range over 4 s
   localparam int RAMP_TICK_CYC = RAMP_TIME_CYC / 60;
   localparam logic [TW-1:0] STEP_CYC = TW'(`US_TO_CYC(100));

   // ----------------------------------------
   // Input synchroniser
   // ----------------------------------------
   logic zc_meta_reg, zc_sync_reg, zc_prev_reg;
   logic [SETPOINT_W-1:0] sp_meta_reg, sp_sync_reg;
   // Two flops before any logic sees the pins
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         zc_meta_reg <= 1'b0;
         zc_sync_reg <= 1'b0;
         zc_prev_reg <= 1'b0;
         sp_meta_reg <= '0;
         sp_sync_reg <= '0;
      end else begin
         zc_meta_reg <= mains_zero_cross_input;
         zc_sync_reg <= zc_meta_reg;
         zc_prev_reg <= zc_sync_reg;
         sp_meta_reg <= power_setpoint_knob;
         sp_sync_reg <= sp_meta_reg;
      end
   end
   wire zc_edge = zc_sync_reg ^ zc_prev_reg; // RULE11

   // ----------------------------------------
   // Level quantisation
   // ----------------------------------------
   // Knob split into six equal bands: off plus five levels; monotonic in the setpoint
   wire [SETPOINT_W+2:0] sp_x6 = {3'b000, sp_sync_reg} * (SETPOINT_W+3)'(6);
   wire [2:0] level_next = 3'(sp_x6 >> SETPOINT_W); // RULE1 RULE3
   wire standby = (level_next == 3'd0); // RULE5

   // ----------------------------------------
   // Zero-cross timing, frequency and loss
   // ----------------------------------------
   logic [TW-1:0] since_zc_reg;
   logic lost_reg, is60_reg;
   // Count since the last edge, held once it reaches the timeout, times both the delay and the loss watch
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         since_zc_reg <= '0;
         lost_reg <= 1'b1;
         is60_reg <= 1'b0;
      end else if (zc_edge) begin
         since_zc_reg <= '0;
         lost_reg <= 1'b0; // RULE7
         if (!lost_reg) begin
            is60_reg <= (since_zc_reg < TW'(`US_TO_CYC(`FREQ_SPLIT_US))); // RULE14
         end
      end else if (since_zc_reg >= TW'(ZC_TIMEOUT_CYC)) begin
         lost_reg <= 1'b1; // RULE15 RULE6
      end else begin
         since_zc_reg <= since_zc_reg + TW'(1); // RULE15
      end
   end

   // ----------------------------------------
   // Target delay tables
   // ----------------------------------------
   logic [TW-1:0] tab50 [1:5];
   logic [TW-1:0] tab60 [1:5];
   assign tab50[1] = TW'(`US_TO_CYC(`DLY50_L1_US)); // RULE9
   assign tab50[2] = TW'(`US_TO_CYC(`DLY50_L2_US));
   assign tab50[3] = TW'(`US_TO_CYC(`DLY50_L3_US));
   assign tab50[4] = TW'(`US_TO_CYC(`DLY50_L4_US));
   assign tab50[5] = TW'(`US_TO_CYC(`DLY50_L5_US));
   assign tab60[1] = TW'(`US_TO_CYC(`DLY60_L1_US)); // RULE10
   assign tab60[2] = TW'(`US_TO_CYC(`DLY60_L2_US));
   assign tab60[3] = TW'(`US_TO_CYC(`DLY60_L3_US));
   assign tab60[4] = TW'(`US_TO_CYC(`DLY60_L4_US));
   assign tab60[5] = TW'(`US_TO_CYC(`DLY60_L5_US));
   wire [2:0] lvl_idx = standby ? 3'd1 : level_next;
   wire [TW-1:0] target_dly = is60_reg ? tab60[lvl_idx] : tab50[lvl_idx];

   // ----------------------------------------
   // Soft ramp of the applied delay
   // ----------------------------------------
   logic [TW-1:0] dly_reg;
   logic [TW-1:0] ramp_cnt_reg;
   wire ramp_tick = (ramp_cnt_reg >= TW'(RAMP_TICK_CYC - 1));
   wire [TW-1:0] dly_up = (target_dly - dly_reg > STEP_CYC) ? dly_reg + STEP_CYC : target_dly;
   wire [TW-1:0] dly_dn = (dly_reg - target_dly > STEP_CYC) ? dly_reg - STEP_CYC : target_dly;
   // Standby or loss parks the delay at the softest point so restarts ramp again
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dly_reg <= TW'(`US_TO_CYC(`DLY50_L1_US));
         ramp_cnt_reg <= '0;
      end else begin
         ramp_cnt_reg <= ramp_tick ? '0 : ramp_cnt_reg + TW'(1);
         if (standby || lost_reg) begin
            dly_reg <= tab50[1];
         end else if (ramp_tick) begin
            dly_reg <= (target_dly > dly_reg) ? dly_up : dly_dn; // RULE13
         end
      end
   end

   // ----------------------------------------
   // Firing state machine
   // ----------------------------------------
   fire_state_e state_reg, state_next;
   logic [TW-1:0] pulse_cnt_reg;
   wire pulse_done = (pulse_cnt_reg >= TW'(`US_TO_CYC(`GATE_PULSE_US) - 1)); // RULE12
   // Runs from reset with no start command; a fresh edge restarts the delay, except during a gate pulse, which runs to its end
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_STANDBY: if (!standby && !lost_reg && zc_edge) state_next = ST_DELAY; // RULE8
         ST_DELAY: if (since_zc_reg >= dly_reg) state_next = ST_PULSE; // RULE12
         ST_PULSE: if (pulse_done) state_next = ST_WAIT; // RULE12
         ST_WAIT: if (zc_edge) state_next = ST_DELAY;
         default: state_next = ST_STANDBY;
      endcase
      if (standby || lost_reg) state_next = ST_STANDBY; // RULE5 RULE6
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_STANDBY;
         pulse_cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         pulse_cnt_reg <= (state_reg == ST_PULSE) ? pulse_cnt_reg + TW'(1) : '0;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   logic gate_reg, blink_reg, lamp_reg;
   logic [TW-1:0] blink_cnt_reg;
   logic [4:0] leds_reg;
   logic [2:0] level_reg;
   // All outputs registered; lamp blinks only while the zero cross is missing
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gate_reg <= 1'b0;
         blink_cnt_reg <= '0;
         blink_reg <= 1'b0;
         lamp_reg <= 1'b0;
         leds_reg <= '0;
         level_reg <= '0;
      end else begin
         gate_reg <= (state_next == ST_PULSE);
         blink_cnt_reg <= (blink_cnt_reg >= TW'(BLINK_HALF_CYC - 1)) ? '0
                          : blink_cnt_reg + TW'(1);
         if (blink_cnt_reg >= TW'(BLINK_HALF_CYC - 1)) blink_reg <= ~blink_reg;
         lamp_reg <= lost_reg ? blink_reg : (state_next != ST_STANDBY); // RULE4 RULE6
         level_reg <= level_next; // RULE2
         leds_reg <= standby ? 5'h00 : 5'(5'h01 << (level_next - 3'd1)); // RULE2
      end
   end
   assign triac_gate = gate_reg;
   assign indicators = '{run_lamp: lamp_reg, level_leds: leds_reg};
   assign working_level = level_reg;
   assign mains_60hz = is60_reg;
   assign zc_lost = lost_reg;
endmodule // phase_angle_triac_firing

// ### triac_firing_chk.sv
// Assertion checker for the triac firing controller
`timescale 1ns/1ps
module triac_firing_chk
   import triac_firing_pkg::*;
#(
   parameter int ZC_TIMEOUT_CYC = 300000,
   parameter int BLINK_HALF_CYC = 2500000
) (
   // Clock, reset and mains
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic mains_zero_cross_input,
   // Outputs watched
   input wire logic triac_gate,
   input wire indicator_s indicators,
   input wire logic [2:0] working_level,
   input wire logic zc_lost
);
   int hi_cnt;
   int zc_cnt;
   int lamp_cnt;
   logic zc_d;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Pulse length, edge silence and lamp stability counters
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hi_cnt <= 0;
         zc_cnt <= 0;
         lamp_cnt <= 0;
         zc_d <= 1'b0;
      end else begin
         hi_cnt <= triac_gate ? hi_cnt + 1 : 0;
         zc_d <= mains_zero_cross_input;
         zc_cnt <= (mains_zero_cross_input != zc_d) ? 0 : zc_cnt + 1;
         lamp_cnt <= (zc_lost && working_level != 3'h0 && $stable(indicators.run_lamp)) ?
            lamp_cnt + 1 : 0;
      end
   end
   a_level_range: assert property (working_level <= 3'h5)
      else $error("level out of range");
   a_level_leds: assert property (indicators.level_leds ==
      ((working_level == 3'h0) ? 5'h00 : 5'h01 << (working_level - 3'h1)))
      else $error("level leds wrong");
   a_standby_fire: assert property ($past(working_level) == 3'h0 &&
      working_level == 3'h0 |-> !$rose(triac_gate)) else $error("fired in standby");
   a_lost_fire: assert property ($past(zc_lost) |-> !$rose(triac_gate))
      else $error("fired without mains");
   a_pulse_width: assert property ($fell(triac_gate) |-> hi_cnt == 10000)
      else $error("gate pulse width wrong");
   // Firing waits for the next edge after arming, so the lamp is judged while the gate is driven
   a_lamp_steady: assert property (
      triac_gate |-> indicators.run_lamp)
      else $error("lamp not on");
   a_standby_dark: assert property (
      (!zc_lost && working_level == 3'h0) [*3] |-> !indicators.run_lamp)
      else $error("lamp on in standby");
   a_blink_rate: assert property (lamp_cnt <= BLINK_HALF_CYC + 2)
      else $error("lamp not blinking");
   a_loss_timeout: assert property (zc_cnt > ZC_TIMEOUT_CYC + 5 |-> zc_lost)
      else $error("loss not flagged");
endmodule // triac_firing_chk

// ### mains_zc_model.sv
// Mains zero-cross source and triac gate observer
`timescale 1ns/1ps
module mains_zc_model (
   // Clock and control
   input wire logic core_clk,
   input wire logic run,
   input wire logic [31:0] half_cyc,
   // Power stage
   input wire logic triac_gate,
   output logic zc,
   output int fires
);
   int cnt = 0;
   initial zc = 1'b0;
   initial fires = 0;
   // Level holds when mains is absent, as the detector would leave it
   always @(posedge core_clk) begin
      cnt = run ? cnt + 1 : 0;
      if (cnt >= half_cyc) begin
         zc <= ~zc;
         cnt = 0;
      end
   end
   // Each gate pulse would fire the triac once
   always @(posedge triac_gate) fires = fires + 1;
endmodule // mains_zc_model

// ### phase_angle_triac_firing_test.sv
// Testbench for the triac firing controller
`timescale 1ns/1ps
module phase_angle_triac_firing_test;
   import triac_firing_pkg::*;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic run = 1'b0;
   logic [31:0] half_cyc = 32'd100000;
   logic [7:0] knob = 8'h00;
   logic zc, triac_gate, mains_60hz, zc_lost;
   logic [2:0] working_level;
   indicator_s indicators;
   int fires, failures = 0, check_count = 0, d, w, f;
   logic [7:0] tbl [6] = '{8'h00, 8'h2b, 8'h56, 8'h80, 8'hab, 8'hd6};
   always #50 core_clk = ~core_clk;
   mains_zc_model mains (.core_clk(core_clk), .run(run), .half_cyc(half_cyc),
      .triac_gate(triac_gate), .zc(zc), .fires(fires));
   phase_angle_triac_firing #(.ZC_TIMEOUT_CYC(120000), .RAMP_TIME_CYC(120000),
      .BLINK_HALF_CYC(100)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .mains_zero_cross_input(zc), .power_setpoint_knob(knob), .triac_gate(triac_gate),
      .indicators(indicators), .working_level(working_level), .mains_60hz(mains_60hz),
      .zc_lost(zc_lost));
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %0d seen %0d", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Bounded wait on the gate or the zero-cross line
   task automatic wait_for(bit on_zc, logic want, output int n);
      n = 0;
      while ((on_zc ? zc : triac_gate) !== want) begin
         tick(1);
         n++;
         if (n > 200000) begin
            check("wait", 32'h1, 32'h0);
            end_of_test();
         end
      end
   endtask
   task automatic edges(int k);
      repeat (k) wait_for(1'b1, ~zc, d);
   endtask
   // Delay from a mains edge to the gate, then the gate width
   task automatic fire(output int dly, output int wid);
      wait_for(1'b0, 1'b0, dly);
      edges(1);
      wait_for(1'b0, 1'b1, dly);
      wait_for(1'b0, 1'b0, wid);
   endtask
   initial begin
      tick(20);
      check("lost at reset", zc_lost, 1'b1);
      sys_rst = 1'b0;
      // Bands and their lower boundaries, mains absent
      for (int i = 0; i < 6; i++) begin
         knob = tbl[i];
         tick(6);
         check("level", working_level, i);
         check("leds", indicators.level_leds, (i == 0) ? 0 : 1 << (i - 1));
         if (i > 0) begin
            knob = tbl[i] - 8'h01;
            tick(6);
            check("level below band", working_level, i - 1);
         end
      end
      $display("level test done");
      knob = tbl[5];
      run = 1'b1;
      edges(3);
      fire(d, w);
      check("50 Hz delay", d >= 25000 && d <= 25008, 1'b1);
      check("pulse width", w, 10000);
      check("60 Hz flag", mains_60hz, 1'b0);
      check("lamp", indicators.run_lamp, 1'b1);
      $display("50 Hz test done");
      half_cyc = 32'd83333;
      knob = tbl[1];
      edges(2);
      fire(d, w);
      check("60 Hz delay", d >= 70000 && d <= 70008, 1'b1);
      check("60 Hz flag", mains_60hz, 1'b1);
      knob = 8'h00;
      edges(1);
      f = fires;
      edges(2);
      check("standby fires", fires, f);
      $display("60 Hz and standby test done");
      knob = tbl[5];
      run = 1'b0;
      tick(125000);
      check("lost", zc_lost, 1'b1);
      f = fires;
      w = 0;
      for (int i = 0; i < 1000; i++) begin
         d = indicators.run_lamp;
         tick(1);
         w += (d != indicators.run_lamp);
      end
      check("blinks", w >= 8 && w <= 11, 1'b1);
      check("halted fires", fires, f);
      run = 1'b1;
      // Ramp spans more than a half period, so the first pulse comes late
      edges(1);
      fire(d, w);
      check("ramp start", d >= 25000 && d <= 40000, 1'b1);
      edges(2);
      fire(d, w);
      check("lost cleared", zc_lost, 1'b0);
      check("resumed delay", d >= 20000 && d <= 20008, 1'b1);
      $display("loss test done");
      end_of_test();
   end
endmodule // phase_angle_triac_firing_test
bind phase_angle_triac_firing triac_firing_chk #(.ZC_TIMEOUT_CYC(ZC_TIMEOUT_CYC),
   .BLINK_HALF_CYC(BLINK_HALF_CYC)) chk (.core_clk(core_clk), .sys_rst(sys_rst),
   .mains_zero_cross_input(mains_zero_cross_input), .triac_gate(triac_gate),
   .indicators(indicators), .working_level(working_level), .zc_lost(zc_lost));
